// ==== hdl/relay_mux_ctrl.sv ====
// Switch-state control for the 48-channel relay multiplexer.
`timescale 1ns/100ps
`default_nettype none
module relay_mux_ctrl
  import relay_mux_pkg::*;
(
  // Clock, reset and enable
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  // Environment levels
  input wire logic [SLOT_W-1:0] MY_SLOT_IN,
  input wire logic TERM_PRESENT_IN,
  input wire logic OVERVOLT_IN,
  input wire logic RIBBON_MODE_IN,
  input wire logic SCAN_STEP_KEY_IN,
  // Command from the mainframe controller
  input wire logic CMD_VALID_IN,
  input wire logic [2:0] CMD_OP_IN,
  input wire logic [ADDR_W-1:0] CMD_ADDR_IN,
  // Switch drives
  output logic [CHAN_COUNT-1:0] CHAN_CLOSED_OUT,
  output logic ISO_RELAY_OUT,
  output logic [1:0] SOURCE_TREE_OUT,
  output logic [1:0] SENSE_TREE_OUT,
  output logic SCAN_ACTIVE_OUT,
  output logic [CHAN_W-1:0] SCAN_CHAN_OUT,
  // Answer to the controller
  output logic RESP_VALID_OUT,
  output logic RESP_ERR_OUT,
  output logic [19:0] RESP_DATA_OUT
);

  // ==========================================================
  // Bank map
  logic [CHAN_COUNT-1:0] bank_b_map;
  genvar gi;
  generate
    for (gi = 0; gi < CHAN_COUNT; gi++)
    begin : g_bank
      assign bank_b_map[gi] = ((7'(gi) % BANK_PERIOD) >= BANK_HALF);
    end
  endgenerate

  function automatic logic [CHAN_COUNT-1:0] close_one(input logic [CHAN_COUNT-1:0] cur,
                                                       input logic [CHAN_COUNT-1:0] map,
                                                       input logic bank,
                                                       input logic [CHAN_W-1:0] idx);
    logic [CHAN_COUNT-1:0] mask;
    mask = bank ? map : ~map;
    return (cur & ~mask) | ({{(CHAN_COUNT-1){1'b0}}, 1'b1} << idx);
  endfunction

  // ==========================================================
  // State
  state_s st_ff;
  state_s nxt;
  logic [10:0] base;
  logic [10:0] addr_ext;
  logic in_slot;
  logic [6:0] local_ch;
  logic is_bank_ch;
  logic is_elem;
  logic [CHAN_W-1:0] ch_idx;
  logic ch_bank;
  logic close_v;
  logic sns_on;
  logic src_on;
  cmd_op_e op;

  always_comb
  begin
    nxt = st_ff;
    nxt.resp_valid = 1'b0;
    nxt.resp_err = 1'b0;
    nxt.resp_data = '0;
    op = cmd_op_e'(CMD_OP_IN);
    base = {7'h00, MY_SLOT_IN} * SLOT_SPAN;
    addr_ext = {1'b0, CMD_ADDR_IN};
    in_slot = CMD_VALID_IN && (addr_ext >= base) && (addr_ext < base + SLOT_SPAN);
    local_ch = 7'(addr_ext - base);
    is_bank_ch = local_ch < CHAN_LIMIT;
    is_elem = (local_ch >= CH_ISO) && (local_ch <= CH_OHMS4);
    ch_idx = local_ch[CHAN_W-1:0];
    ch_bank = bank_b_map[ch_idx];
    close_v = (op == OP_CLOSE);
    sns_on = st_ff.sns_out[ch_bank];
    src_on = st_ff.src_out[ch_bank];
    if (!st_ff.id_done)
    begin
      nxt.id_done = 1'b1;
      nxt.id_code = TERM_PRESENT_IN ? ID_WITH_TERM : ID_GENERIC;
    end
    if (st_ff.scan_act && SCAN_STEP_KEY_IN)
    begin
      if (st_ff.scan_ch == CH_LAST)
      begin
        nxt.scan_act = 1'b0;
      end
      else
      begin
        nxt.scan_ch = st_ff.scan_ch + CH_STEP;
        nxt.closed = close_one(st_ff.closed, bank_b_map, bank_b_map[nxt.scan_ch], nxt.scan_ch);
        nxt.sel_bank = bank_b_map[nxt.scan_ch];
      end
    end
    // A command in the same cycle as a key press is applied on top of the step.
    if (in_slot)
    begin
      nxt.resp_valid = 1'b1;
      unique case (op)
        OP_CLOSE, OP_OPEN:
        begin
          if (is_bank_ch && close_v)
          begin
            nxt.closed = close_one(nxt.closed, bank_b_map, ch_bank, ch_idx);
            nxt.sel_bank = ch_bank;
          end
          else if (is_bank_ch)
          begin
            nxt.closed[ch_idx] = 1'b0;
          end
          else if (local_ch == CH_ISO)
          begin
            nxt.iso_cmd = close_v;
          end
          else if (local_ch == CH_SRC_TREE)
          begin
            nxt.src_cmd = close_v;
          end
          else if (local_ch == CH_SNS_TREE)
          begin
            nxt.sns_cmd = close_v;
          end
          else if (local_ch == CH_OHMS2)
          begin
            nxt.src_cmd = close_v;
            nxt.sns_cmd = close_v;
          end
          else if (local_ch == CH_OHMS4)
          begin
            nxt.four_wire = close_v;
          end
          else
          begin
            nxt.resp_err = 1'b1;
          end
        end
        OP_QUERY:
        begin
          if (is_bank_ch)
          begin
            if (!st_ff.closed[ch_idx])
              nxt.resp_data = resp_t'(QS_OPEN);
            else if (sns_on && src_on)
              nxt.resp_data = resp_t'(QS_BOTH);
            else if (src_on)
              nxt.resp_data = resp_t'(QS_SOURCE);
            else if (sns_on)
              nxt.resp_data = resp_t'(QS_SENSE);
            else
              nxt.resp_data = resp_t'(QS_NO_BUS);
          end
          else if (is_elem)
          begin
            unique case (local_ch)
              CH_ISO: nxt.resp_data = resp_t'(st_ff.iso_cmd);
              CH_SRC_TREE: nxt.resp_data = resp_t'(st_ff.src_cmd || st_ff.four_wire);
              CH_SNS_TREE: nxt.resp_data = resp_t'(st_ff.sns_cmd || st_ff.four_wire);
              CH_OHMS2: nxt.resp_data = resp_t'(st_ff.src_cmd && st_ff.sns_cmd);
              default: nxt.resp_data = resp_t'(st_ff.four_wire);
            endcase
          end
          else
          begin
            nxt.resp_err = 1'b1;
          end
        end
        OP_IDENT:
        begin
          nxt.resp_data = nxt.id_code;
        end
        OP_RESET:
        begin
          nxt.closed = '0;
          nxt.iso_cmd = 1'b0;
          nxt.src_cmd = 1'b0;
          nxt.sns_cmd = 1'b0;
          nxt.four_wire = 1'b0;
          nxt.sel_bank = 1'b0;
          nxt.scan_act = 1'b0;
          nxt.scan_ch = '0;
        end
        OP_MEASURE, OP_SCAN:
        begin
          if (is_bank_ch)
          begin
            nxt.closed = close_one(nxt.closed, bank_b_map, ch_bank, ch_idx);
            nxt.sel_bank = ch_bank;
            nxt.iso_cmd = 1'b1;
            nxt.sns_cmd = 1'b1;
            nxt.src_cmd = 1'b0;
            nxt.four_wire = 1'b0;
            nxt.scan_act = (op == OP_SCAN);
            nxt.scan_ch = ch_idx;
          end
          else
          begin
            nxt.resp_err = 1'b1;
          end
        end
        default:
        begin
          nxt.resp_err = 1'b1;
        end
      endcase
    end
    nxt.iso_out = nxt.iso_cmd && !OVERVOLT_IN && !RIBBON_MODE_IN;
    // only the selected bank reaches the buses; 4-wire uses one of each
    if (nxt.four_wire)
    begin
      nxt.sns_out = TREE_BANK0;
      nxt.src_out = TREE_BANK1;
    end
    else
    begin
      nxt.sns_out = !nxt.sns_cmd ? TREE_NONE : (nxt.sel_bank ? TREE_BANK1 : TREE_BANK0);
      nxt.src_out = !nxt.src_cmd ? TREE_NONE : (nxt.sel_bank ? TREE_BANK1 : TREE_BANK0);
    end
  end

  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      st_ff <= '0;
    else if (CLK_EN_IN)
      st_ff <= nxt;
  end

  assign CHAN_CLOSED_OUT = st_ff.closed;
  assign ISO_RELAY_OUT = st_ff.iso_out;
  assign SOURCE_TREE_OUT = st_ff.src_out;
  assign SENSE_TREE_OUT = st_ff.sns_out;
  assign SCAN_ACTIVE_OUT = st_ff.scan_act;
  assign SCAN_CHAN_OUT = st_ff.scan_ch;
  assign RESP_VALID_OUT = st_ff.resp_valid;
  assign RESP_ERR_OUT = st_ff.resp_err;
  assign RESP_DATA_OUT = st_ff.resp_data;

  // ==========================================================
  // Checks
  property p_bank_excl;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    $onehot0(CHAN_CLOSED_OUT & bank_b_map) && $onehot0(CHAN_CLOSED_OUT & ~bank_b_map);
  endproperty
  a_bank_excl: assert property (p_bank_excl) else $error("two channels closed in a bank");

  property p_route;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && in_slot && op == OP_MEASURE && is_bank_ch)
      |=> SENSE_TREE_OUT == ($past(ch_bank) ? TREE_BANK1 : TREE_BANK0);
  endproperty
  a_route: assert property (p_route) else $error("sense bus routed to wrong bank");

  property p_iso_elem;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && in_slot && op == OP_CLOSE && local_ch == CH_ISO && !OVERVOLT_IN && !RIBBON_MODE_IN)
      |=> ISO_RELAY_OUT;
  endproperty
  a_iso_elem: assert property (p_iso_elem) else $error("relay element did not close");

  property p_ohms2;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && in_slot && op == OP_CLOSE && local_ch == CH_OHMS2)
      |=> (SENSE_TREE_OUT != TREE_NONE) && (SOURCE_TREE_OUT != TREE_NONE);
  endproperty
  a_ohms2: assert property (p_ohms2) else $error("2-wire pair not closed");

  property p_ovp;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && OVERVOLT_IN) |=> !ISO_RELAY_OUT;
  endproperty
  a_ovp: assert property (p_ovp) else $error("relays closed under overvoltage");

  property p_ribbon;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && RIBBON_MODE_IN) |=> !ISO_RELAY_OUT;
  endproperty
  a_ribbon: assert property (p_ribbon) else $error("relays closed in ribbon mode");

  property p_id_fixed;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    st_ff.id_done |=> $stable(st_ff.id_code) && st_ff.id_done;
  endproperty
  a_id_fixed: assert property (p_id_fixed) else $error("identity changed after power-on");

  property p_idle_tree;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    !st_ff.four_wire |-> (SENSE_TREE_OUT & (st_ff.sel_bank ? TREE_BANK0 : TREE_BANK1)) == TREE_NONE;
  endproperty
  a_idle_tree: assert property (p_idle_tree) else $error("unused bank tree closed");

  property p_measure;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && in_slot && op == OP_MEASURE && is_bank_ch)
      |=> CHAN_CLOSED_OUT[$past(ch_idx)] && st_ff.iso_cmd;
  endproperty
  a_measure: assert property (p_measure) else $error("measure path not closed");

  property p_foreign;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && !in_slot) |=> !RESP_VALID_OUT;
  endproperty
  a_foreign: assert property (p_foreign) else $error("answered foreign address");

  property p_scan_end;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && SCAN_ACTIVE_OUT && SCAN_STEP_KEY_IN && SCAN_CHAN_OUT == CH_LAST && !in_slot)
      |=> !SCAN_ACTIVE_OUT && SCAN_CHAN_OUT == CH_LAST;
  endproperty
  a_scan_end: assert property (p_scan_end) else $error("scan did not stop at last channel");

  property p_query_open;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && in_slot && op == OP_QUERY && is_bank_ch && !CHAN_CLOSED_OUT[ch_idx])
      |=> RESP_VALID_OUT && RESP_DATA_OUT == resp_t'(QS_OPEN);
  endproperty
  a_query_open: assert property (p_query_open) else $error("open channel not reported 0");

  property p_query_elem;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && in_slot && op == OP_QUERY && is_elem) |=> RESP_DATA_OUT <= resp_t'(QS_CLOSED);
  endproperty
  a_query_elem: assert property (p_query_elem) else $error("element query above 1");

  property p_reset_cmd;
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (CLK_EN_IN && in_slot && op == OP_RESET)
      |=> CHAN_CLOSED_OUT == '0 && !ISO_RELAY_OUT && SENSE_TREE_OUT == TREE_NONE && SOURCE_TREE_OUT == TREE_NONE;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset left a switch closed");

endmodule
`default_nettype wire

// ==== hdl/relay_mux_pkg.sv ====
// Constants, command codes and state layout for the relay multiplexer switch control.
package relay_mux_pkg;
  // ==========================================================
  // Sizes and addressing
  localparam int CHAN_COUNT = 48;
  localparam int CHAN_W = 6;
  localparam int ADDR_W = 10;
  localparam int SLOT_W = 4;
  localparam logic [10:0] SLOT_SPAN = 11'h064;
  localparam logic [6:0] BANK_PERIOD = 7'h18;
  localparam logic [6:0] BANK_HALF = 7'h0c;
  localparam logic [6:0] CHAN_LIMIT = 7'h30;
  localparam logic [5:0] CH_LAST = 6'h2f;
  localparam logic [5:0] CH_STEP = 6'h01;
  // ==========================================================
  // Special element channels
  localparam logic [6:0] CH_ISO = 7'h5a;
  localparam logic [6:0] CH_SRC_TREE = 7'h5b;
  localparam logic [6:0] CH_SNS_TREE = 7'h5c;
  localparam logic [6:0] CH_OHMS2 = 7'h5d;
  localparam logic [6:0] CH_OHMS4 = 7'h5e;
  // ==========================================================
  // Tree switch patterns, bit 0 is the first bank
  localparam logic [1:0] TREE_NONE = 2'h0;
  localparam logic [1:0] TREE_BANK0 = 2'h1;
  localparam logic [1:0] TREE_BANK1 = 2'h2;
  // ==========================================================
  // Query answers
  localparam logic [2:0] QS_OPEN = 3'h0;
  localparam logic [2:0] QS_NO_BUS = 3'h1;
  localparam logic [2:0] QS_SENSE = 3'h2;
  localparam logic [2:0] QS_SOURCE = 3'h3;
  localparam logic [2:0] QS_BOTH = 3'h4;
  localparam logic [2:0] QS_CLOSED = 3'h1;
  // ==========================================================
  // Identity codes; both values are arbitrary.
  typedef logic [19:0] resp_t;
  localparam resp_t ID_WITH_TERM = 20'h5a3c1;
  localparam resp_t ID_GENERIC = 20'h5a0ff;
  // ==========================================================
  // Commands
  typedef enum logic [2:0] {
    OP_CLOSE = 3'h0,
    OP_OPEN = 3'h1,
    OP_QUERY = 3'h2,
    OP_IDENT = 3'h3,
    OP_RESET = 3'h4,
    OP_MEASURE = 3'h5,
    OP_SCAN = 3'h6
  } cmd_op_e;
  // ==========================================================
  // Whole module state
  typedef struct packed {
    logic [CHAN_COUNT-1:0] closed;
    logic sel_bank;
    logic iso_cmd;
    logic src_cmd;
    logic sns_cmd;
    logic four_wire;
    logic iso_out;
    logic [1:0] src_out;
    logic [1:0] sns_out;
    logic scan_act;
    logic [CHAN_W-1:0] scan_ch;
    logic id_done;
    resp_t id_code;
    logic resp_valid;
    logic resp_err;
    resp_t resp_data;
  } state_s;
endpackage

// ==== tb/mainframe_ctrl_model.sv ====
// Behavioural model of the mainframe controller that sends slot commands.
`timescale 1ns/100ps
`default_nettype none
module mainframe_ctrl_model
  import relay_mux_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Command word to the multiplexer
  output logic cmd_valid_out,
  output logic [2:0] cmd_op_out,
  output logic [ADDR_W-1:0] cmd_addr_out
);
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_op_out = 3'h7;
    cmd_addr_out = 10'h3ff;
  end

  // ==========================================================
  // Command issue
  // Released lines show the inverse, so a stale word never looks like a new one.
  task automatic send(input logic [2:0] op, input logic [ADDR_W-1:0] addr);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_op_out = op;
    cmd_addr_out = addr;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_op_out = ~op;
    cmd_addr_out = ~addr;
  endtask

  task automatic close_voltage_path(input logic [ADDR_W-1:0] base, input logic [5:0] ch);
    send(OP_CLOSE, base + {4'h0, ch});
    send(OP_CLOSE, base + 10'h05a);
    send(OP_CLOSE, base + 10'h05c);
  endtask
endmodule
`default_nettype wire

// ==== tb/relay_mux_channel_switch_control_bench.sv ====
// Self-checking bench for the relay multiplexer switch control.
`timescale 1ns/100ps
`default_nettype none
module relay_mux_channel_switch_control_bench
  import relay_mux_pkg::*;
;
  // ==========================================================
  // Pins
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic term = 1'b1;
  logic ovv = 1'b0;
  logic ribbon = 1'b0;
  logic step = 1'b0;
  logic en = 1'b1;
  logic cmd_v;
  logic [2:0] cmd_op;
  logic [ADDR_W-1:0] cmd_addr;
  logic [CHAN_COUNT-1:0] closed;
  logic iso;
  logic [1:0] src;
  logic [1:0] sns;
  logic scan_act;
  logic [CHAN_W-1:0] scan_ch;
  logic rsp_v;
  logic rsp_e;
  logic [19:0] rsp_d;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  relay_mux_ctrl dut_u (
    .MCLK_IN(mclk),
    .RESET_IN(rst),
    .CLK_EN_IN(en),
    .MY_SLOT_IN(4'h5),
    .TERM_PRESENT_IN(term),
    .OVERVOLT_IN(ovv),
    .RIBBON_MODE_IN(ribbon),
    .SCAN_STEP_KEY_IN(step),
    .CMD_VALID_IN(cmd_v),
    .CMD_OP_IN(cmd_op),
    .CMD_ADDR_IN(cmd_addr),
    .CHAN_CLOSED_OUT(closed),
    .ISO_RELAY_OUT(iso),
    .SOURCE_TREE_OUT(src),
    .SENSE_TREE_OUT(sns),
    .SCAN_ACTIVE_OUT(scan_act),
    .SCAN_CHAN_OUT(scan_ch),
    .RESP_VALID_OUT(rsp_v),
    .RESP_ERR_OUT(rsp_e),
    .RESP_DATA_OUT(rsp_d)
  );

  mainframe_ctrl_model ctl_u (
    .clk_in(mclk),
    .cmd_valid_out(cmd_v),
    .cmd_op_out(cmd_op),
    .cmd_addr_out(cmd_addr)
  );

  // ==========================================================
  // Helpers
  task automatic finish_test();
    $display("Checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [47:0] b(input int n);
    return 48'h1 << n;
  endfunction

  // Slot 5 is fixed, so every local channel sits at 500 plus its number.
  task automatic cmd(input logic [2:0] op, input int ch, input logic err = 1'b0);
    ctl_u.send(op, 10'(500 + ch));
    check(rsp_v, 1'b1);
    check(rsp_e, err);
  endtask

  task automatic ask(input int ch, input logic [2:0] code);
    cmd(OP_QUERY, ch);
    check(rsp_d, {17'h0, code});
  endtask

  task automatic sw(input logic [47:0] c, input logic i, input logic [1:0] se, input logic [1:0] so);
    check(closed, c);
    check(iso, i);
    check(sns, se);
    check(src, so);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_identity();
    sw(48'h0, 1'b0, TREE_NONE, TREE_NONE);
    cmd(OP_IDENT, 0);
    check(rsp_d, ID_WITH_TERM);
    term = 1'b0;
    cmd(OP_RESET, 0);
    cmd(OP_IDENT, 0);
    check(rsp_d, ID_WITH_TERM);
    rst = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    cmd(OP_IDENT, 0);
    check(rsp_d, ID_GENERIC);
    term = 1'b1;
    cmd(OP_IDENT, 0);
    check(rsp_d, ID_GENERIC);
    $display("Test identity done");
  endtask

  task automatic t_bank();
    cmd(OP_CLOSE, 3);
    cmd(OP_CLOSE, 7);
    check(closed, b(7));
    cmd(OP_CLOSE, 15);
    cmd(OP_CLOSE, 47);
    check(closed, b(7) | b(47));
    cmd(OP_CLOSE, 24);
    check(closed, b(24) | b(47));
    ctl_u.send(OP_CLOSE, 10'h25b);
    check(rsp_v, 1'b0);
    cmd(OP_CLOSE, 48, 1'b1);
    cmd(3'h7, 0, 1'b1);
    check(closed, b(24) | b(47));
    $display("Test bank done");
  endtask

  task automatic t_tree();
    cmd(OP_RESET, 0);
    ctl_u.close_voltage_path(10'h1f4, 6'h03);
    sw(b(3), 1'b1, TREE_BANK0, TREE_NONE);
    ask(3, QS_SENSE);
    ask(90, QS_CLOSED);
    ask(91, QS_OPEN);
    cmd(OP_CLOSE, 15);
    sw(b(3) | b(15), 1'b1, TREE_BANK1, TREE_NONE);
    ask(3, QS_NO_BUS);
    cmd(OP_CLOSE, 91);
    check(src, TREE_BANK1);
    ask(15, QS_BOTH);
    ask(0, QS_OPEN);
    $display("Test tree done");
  endtask

  task automatic t_ohms();
    cmd(OP_RESET, 0);
    cmd(OP_CLOSE, 15);
    cmd(OP_CLOSE, 93);
    sw(b(15), 1'b0, TREE_BANK1, TREE_BANK1);
    cmd(OP_CLOSE, 94);
    cmd(OP_CLOSE, 3);
    sw(b(3) | b(15), 1'b0, TREE_BANK0, TREE_BANK1);
    ask(15, QS_SOURCE);
    $display("Test ohms done");
  endtask

  task automatic t_iso();
    cmd(OP_RESET, 0);
    cmd(OP_CLOSE, 90);
    check(iso, 1'b1);
    ovv = 1'b1;
    @(negedge mclk);
    check(iso, 1'b0);
    ask(90, QS_CLOSED);
    check(iso, 1'b0);
    ovv = 1'b0;
    repeat (2) @(negedge mclk);
    check(iso, 1'b1);
    ribbon = 1'b1;
    @(negedge mclk);
    check(iso, 1'b0);
    repeat (3) @(negedge mclk);
    check(iso, 1'b0);
    ribbon = 1'b0;
    $display("Test iso done");
  endtask

  task automatic t_measure();
    cmd(OP_RESET, 0);
    cmd(OP_MEASURE, 20);
    sw(b(20), 1'b1, TREE_BANK1, TREE_NONE);
    cmd(OP_MEASURE, 90, 1'b1);
    $display("Test measure done");
  endtask

  task automatic press();
    @(negedge mclk);
    step = 1'b1;
    @(negedge mclk);
    step = 1'b0;
  endtask

  task automatic t_scan();
    cmd(OP_RESET, 0);
    cmd(OP_SCAN, 45);
    check(scan_act, 1'b1);
    check(scan_ch, 6'h2d);
    press();
    check(scan_ch, 6'h2e);
    check(closed, b(46));
    press();
    check(scan_ch, 6'h2f);
    press();
    check(scan_act, 1'b0);
    check(closed, b(47));
    $display("Test scan done");
  endtask

  task automatic t_reset_cmd();
    cmd(OP_CLOSE, 90);
    cmd(OP_CLOSE, 92);
    cmd(OP_RESET, 0);
    sw(48'h0, 1'b0, TREE_NONE, TREE_NONE);
    ask(47, QS_OPEN);
    ask(90, QS_OPEN);
    $display("Test reset_cmd done");
  endtask

  // A command offered while the enable is low is lost, and the switches hold.
  task automatic t_enable();
    cmd(OP_CLOSE, 5);
    en = 1'b0;
    ctl_u.send(OP_CLOSE, 10'(506));
    check(closed, b(5));
    en = 1'b1;
    @(negedge mclk);
    check(rsp_v, 1'b0);
    check(closed, b(5));
    cmd(OP_CLOSE, 6);
    check(closed, b(6));
    $display("Test enable done");
  endtask

  // ==========================================================
  // Main sequence and hang guard
  initial
  begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    t_identity();
    t_bank();
    t_tree();
    t_ohms();
    t_iso();
    t_measure();
    t_scan();
    t_reset_cmd();
    t_enable();
    finish_test();
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      $display("Error at %0t: timeout after %0d cycles", $time, cycles);
      finish_test();
    end
  end
endmodule
`default_nettype wire
